// >>> core/ifpd_pkg.sv
// Package of constants for the IF divider programming block
package ifpd_pkg;
	localparam int WORD_W = 24;
	localparam int FB_B_W = 9;
	localparam int FB_A_W = 4;
	localparam int REF_W = 9;
	// Field positions in the divider counter word
	localparam int FB_B_LSB = 4;
	localparam int FB_A_LSB = 13;
	// Field position in the reference divider word
	localparam int REF_LSB = 5;
	// Address codes in the low bits
	localparam logic [3:0] ADDR_DIV = 4'h7;
	localparam logic [4:0] ADDR_REF = 5'h0F;
	localparam logic [5:0] ADDR_TEST = 6'h1F;
	// Main control word: 2-bit address 00, defaults select at bit 2 (chosen)
	localparam logic [1:0] ADDR_MAIN = 2'h0;
	localparam int DEF_BIT = 2;
	// Values after reset, then the full word bit count
	localparam logic RST_DEF = 1'b1;
	localparam logic [8:0] RST_FB_B = 9'h001;
	localparam logic [3:0] RST_FB_A = 4'h0;
	localparam logic [8:0] RST_REF = 9'h002;
	localparam logic [23:0] RST_TEST = 24'h000000;
	localparam logic [4:0] CNT_W = 5'h18;
endpackage

// >>> core/ifpd_shift.sv
// Serial input shift register with bit counter
`timescale 1ns/1ps
`default_nettype none
module ifpd_shift (
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire logic data_in,
	input wire logic sclk_rise_in,
	input wire logic clear_in,
	output logic [23:0] word_out,
	output logic [4:0] count_out
);
	logic [23:0] next_word;
	logic [4:0] next_count;

	// Shift MSB first; count saturates so long words keep the last 24 bits
	always_comb begin
		next_word = word_out;
		next_count = count_out;
		if (clear_in) begin
			next_count = 5'h00;
		end
		if (sclk_rise_in) begin
			next_word = {word_out[22:0], data_in};
			if (count_out != ifpd_pkg::CNT_W)
				next_count = (clear_in ? 5'h00 : count_out) + 5'h01;
		end
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			word_out <= 24'h000000;
			count_out <= 5'h00;
		end else begin
			word_out <= next_word;
			count_out <= next_count;
		end
	end
endmodule
`default_nettype wire

// >>> core/ifpd_top.sv
// Serially programmed IF divider configuration registers
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Feedback binary counter is 9 bits at divider word bits 12:4.
// - Swallow counter is 4 bits at divider word bits 16:13.
// - Swallow counter takes any value 0 through 15.
// - Reference word recognised by address 01111 in bits 4:0.
// - Reference word applies only while defaults select is zero.
// - Reference division taken from reference word bits 13:5.
// - Test word recognised by address in bits 5:0, not for users.
// - Test word honoured only while defaults select is zero.
// - Divider word selected by address 0111, active when defaults clear.
// - Words are 24 bits, MSB first, address in low bits.
module ifpd_top (
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire logic serial_clock_in,
	input wire logic serial_data_in,
	input wire logic latch_strobe_in,
	output logic serial_defaults_select_out,
	output logic [8:0] fb_binary_out,
	output logic [3:0] fb_swallow_out,
	output logic [8:0] ref_divide_out,
	output logic [23:0] test_word_out
);
	logic sclk_q;
	logic le_q;
	logic sclk_rise;
	logic le_rise;
	logic [23:0] word;
	logic [4:0] count;
	logic full;
	logic next_def;
	logic [8:0] next_fb_b;
	logic [3:0] next_fb_a;
	logic [8:0] next_ref;
	logic [23:0] next_test;

	// Edge detection on the serial pins, taken as synchronous
	assign sclk_rise = serial_clock_in & ~sclk_q;
	assign le_rise = latch_strobe_in & ~le_q;
	assign full = (count == ifpd_pkg::CNT_W);

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sclk_q <= 1'b0;
			le_q <= 1'b0;
		end else begin
			sclk_q <= serial_clock_in;
			le_q <= latch_strobe_in;
		end
	end

	ifpd_shift u_shift (
		.clock_in(clock_in),
		.resetn_in(resetn_in),
		.data_in(serial_data_in),
		.sclk_rise_in(sclk_rise),
		.clear_in(le_rise),
		.word_out(word),
		.count_out(count)
	);

	// Decode the latched word; shorter codes checked after longer to avoid aliasing
	always_comb begin
		next_def = serial_defaults_select_out;
		next_fb_b = fb_binary_out;
		next_fb_a = fb_swallow_out;
		next_ref = ref_divide_out;
		next_test = test_word_out;
		// transfer on latch rise after full word
		if (le_rise && full) begin
			if (word[5:0] == ifpd_pkg::ADDR_TEST) begin
				if (!serial_defaults_select_out)
					next_test = word;
			end else if (word[4:0] == ifpd_pkg::ADDR_REF) begin
				if (!serial_defaults_select_out)
					next_ref = word[ifpd_pkg::REF_LSB +: ifpd_pkg::REF_W];
			end else if (word[3:0] == ifpd_pkg::ADDR_DIV) begin
				if (!serial_defaults_select_out) begin
					next_fb_b = word[ifpd_pkg::FB_B_LSB +: ifpd_pkg::FB_B_W];
					// swallow counter field, full 0..15 kept
					next_fb_a = word[ifpd_pkg::FB_A_LSB +: ifpd_pkg::FB_A_W];
				end
			end else if (word[1:0] == ifpd_pkg::ADDR_MAIN) begin
				next_def = word[ifpd_pkg::DEF_BIT];
			end
		end
	end

	// Outputs registered; defaults select starts set so built-in ratios hold
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			serial_defaults_select_out <= ifpd_pkg::RST_DEF;
			fb_binary_out <= ifpd_pkg::RST_FB_B;
			fb_swallow_out <= ifpd_pkg::RST_FB_A;
			ref_divide_out <= ifpd_pkg::RST_REF;
			test_word_out <= ifpd_pkg::RST_TEST;
		end else begin
			serial_defaults_select_out <= next_def;
			fb_binary_out <= next_fb_b;
			fb_swallow_out <= next_fb_a;
			ref_divide_out <= next_ref;
			test_word_out <= next_test;
		end
	end

	// divider fields follow a latched divider word
	a_div_load: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(le_rise && full && word[3:0] == 4'h7 && word[4] == 1'b0 && !serial_defaults_select_out)
		|=> (fb_binary_out == $past(word[12:4]) && fb_swallow_out == $past(word[16:13])))
		else $error("divider word not loaded");

	// reference field loads from bits 13:5
	a_ref_load: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(le_rise && full && word[4:0] == 5'h0F && !serial_defaults_select_out)
		|=> ref_divide_out == $past(word[13:5]))
		else $error("reference word not loaded");

	a_ref_gated: assert property (@(posedge clock_in) disable iff (!resetn_in)
		serial_defaults_select_out |=> $stable(ref_divide_out))
		else $error("reference changed under defaults");

	a_div_gated: assert property (@(posedge clock_in) disable iff (!resetn_in)
		serial_defaults_select_out |=> ($stable(fb_binary_out) && $stable(fb_swallow_out)))
		else $error("divider changed under defaults");

	a_test_gated: assert property (@(posedge clock_in) disable iff (!resetn_in)
		serial_defaults_select_out |=> $stable(test_word_out))
		else $error("test word changed under defaults");

	a_test_load: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(le_rise && full && word[5:0] == 6'h1F && !serial_defaults_select_out)
		|=> test_word_out == $past(word))
		else $error("test word not loaded");

	// nothing changes without a latch rise
	a_no_latch: assert property (@(posedge clock_in) disable iff (!resetn_in)
		!(le_rise && full) |=> ($stable(ref_divide_out) && $stable(fb_binary_out)
		&& $stable(fb_swallow_out) && $stable(test_word_out)
		&& $stable(serial_defaults_select_out)))
		else $error("register changed without latch");

	// a reference word leaves the divider alone
	a_ref_only: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(le_rise && full && word[4:0] == 5'h0F)
		|=> ($stable(fb_binary_out) && $stable(fb_swallow_out) && $stable(test_word_out)))
		else $error("reference word hit divider");

	a_short_word: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(le_rise && count < 5'h18) |=> ($stable(serial_defaults_select_out)
		&& $stable(ref_divide_out) && $stable(fb_binary_out) && $stable(test_word_out)))
		else $error("short word transferred");

	// main control word sets defaults select
	a_main_load: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(le_rise && full && word[1:0] == 2'h0)
		|=> serial_defaults_select_out == $past(word[2]))
		else $error("defaults select not loaded");

	// test word leaves the dividers alone
	a_test_only: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(le_rise && full && word[5:0] == 6'h1F) |=> ($stable(fb_binary_out)
		&& $stable(fb_swallow_out) && $stable(ref_divide_out)))
		else $error("test word hit divider");

	// divider word leaves reference and test alone
	a_div_only: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(le_rise && full && word[3:0] == 4'h7) |=> ($stable(ref_divide_out)
		&& $stable(test_word_out) && $stable(serial_defaults_select_out)))
		else $error("divider word hit other registers");

	a_unknown_addr: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(le_rise && full && word[1:0] != 2'h0 && word[3:0] != 4'h7 && word[4:0] != 5'h0F
		&& word[5:0] != 6'h1F) |=> ($stable(fb_binary_out) && $stable(fb_swallow_out)
		&& $stable(ref_divide_out) && $stable(test_word_out)
		&& $stable(serial_defaults_select_out)))
		else $error("unknown address changed a register");

	// Checks on the serial capture path
	// each sampled bit enters at the bottom
	a_shift_in: assert property (@(posedge clock_in) disable iff (!resetn_in)
		sclk_rise |=> word == {$past(word[22:0]), $past(serial_data_in)})
		else $error("serial bit not shifted in");

	a_word_hold: assert property (@(posedge clock_in) disable iff (!resetn_in)
		!sclk_rise |=> $stable(word))
		else $error("shift word moved without a bit");

	// bit count advances by one per bit until full
	a_count_step: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(sclk_rise && !le_rise && count < 5'h18) |=> count == $past(count) + 5'h01)
		else $error("bit count did not advance");

	// count never passes a full word
	a_count_cap: assert property (@(posedge clock_in) disable iff (!resetn_in)
		count <= 5'h18)
		else $error("bit count passed a full word");

	// latch rise without a bit clears the count
	a_count_clear: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(le_rise && !sclk_rise) |=> count == 5'h00)
		else $error("bit count not cleared by latch");
endmodule
`default_nettype wire

// >>> test/ifpd_host.sv
// Host model that shifts configuration words into the serial port
`timescale 1ns/1ps
`default_nettype none
module ifpd_host (
	input wire logic clock_in,
	output logic serial_clock_out,
	output logic serial_data_out,
	output logic latch_strobe_out
);
	initial begin
		serial_clock_out = 1'b0;
		serial_data_out = 1'b0;
		latch_strobe_out = 1'b0;
	end
	// Shift the low nbits of a word top bit first, then pulse the latch strobe
	// nbits may be under 24 for short-word tests, caller keeps fields legal
	task automatic send_word(input logic [23:0] word, input int nbits);
		for (int i = nbits - 1; i >= 0; i--) begin
			@(negedge clock_in);
			serial_data_out = word[i];
			serial_clock_out = 1'b1;
			@(negedge clock_in);
			serial_clock_out = 1'b0;
		end
		@(negedge clock_in);
		// Data is not held after the last bit; flipping it stops a stale bit passing
		serial_data_out = ~serial_data_out;
		latch_strobe_out = 1'b1;
		repeat (2) @(negedge clock_in);
		latch_strobe_out = 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> test/ifpd_top_tb.sv
// Self-checking bench for the IF divider programming registers
`timescale 1ns/1ps
`default_nettype none
module ifpd_top_tb;
	logic clock_in;
	logic resetn_in;
	logic sclk;
	logic sdata;
	logic latch;
	logic def_sel;
	logic [8:0] fb_b;
	logic [3:0] fb_a;
	logic [8:0] ref_div;
	logic [23:0] test_word;
	int fail_count = 0;
	int comparisons = 0;
	ifpd_host host (.clock_in(clock_in), .serial_clock_out(sclk), .serial_data_out(sdata),
		.latch_strobe_out(latch));
	ifpd_top DUT (.clock_in(clock_in), .resetn_in(resetn_in), .serial_clock_in(sclk),
		.serial_data_in(sdata), .latch_strobe_in(latch), .serial_defaults_select_out(def_sel),
		.fb_binary_out(fb_b), .fb_swallow_out(fb_a), .ref_divide_out(ref_div),
		.test_word_out(test_word));
	// 40 MHz system clock
	initial begin
		clock_in = 1'b0;
		forever #12.5 clock_in = ~clock_in;
	end
	// Compare every output at once; a swapped field shows in one line
	task automatic check_all(input logic d, input logic [8:0] b, input logic [3:0] a,
		input logic [8:0] r, input logic [23:0] t);
		comparisons++;
		if ({def_sel, fb_b, fb_a, ref_div, test_word} !== {d, b, a, r, t}) begin
			fail_count++;
			$display("[FAIL] %0t outputs %h %h %h %h %h", $time, def_sel, fb_b, fb_a, ref_div,
				test_word);
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Watchdog well beyond the words sent, about fifty cycles each
	initial begin
		repeat (5000) @(posedge clock_in);
		fail_count++;
		tally_and_finish();
	end
	initial begin
		resetn_in = 1'b0;
		repeat (16) @(negedge clock_in);
		resetn_in = 1'b1;
		check_all(1'b1, 9'h001, 4'h0, 9'h002, 24'h000000);
		host.send_word({7'h00, 4'hF, 9'h1FF, 4'h7}, 24);
		check_all(1'b1, 9'h001, 4'h0, 9'h002, 24'h000000);
		host.send_word(24'h000000, 24);
		check_all(1'b0, 9'h001, 4'h0, 9'h002, 24'h000000);
		host.send_word({7'h00, 4'hF, 9'h1FF, 4'h7}, 24);
		check_all(1'b0, 9'h1FF, 4'hF, 9'h002, 24'h000000);
		host.send_word({7'h00, 4'h9, 9'h0A6, 4'h7}, 24);
		check_all(1'b0, 9'h0A6, 4'h9, 9'h002, 24'h000000);
		host.send_word({7'h00, 4'h0, 9'h001, 4'h7}, 24);
		check_all(1'b0, 9'h001, 4'h0, 9'h002, 24'h000000);
		host.send_word({10'h000, 9'h1FF, 5'h0F}, 24);
		check_all(1'b0, 9'h001, 4'h0, 9'h1FF, 24'h000000);
		host.send_word({10'h000, 9'h0A5, 5'h0F}, 24);
		check_all(1'b0, 9'h001, 4'h0, 9'h0A5, 24'h000000);
		host.send_word(24'h01FFDF, 24);
		check_all(1'b0, 9'h001, 4'h0, 9'h0A5, 24'h01FFDF);
		// A word one bit short must not load
		host.send_word({10'h000, 9'h003, 5'h0F}, 23);
		check_all(1'b0, 9'h001, 4'h0, 9'h0A5, 24'h01FFDF);
		// Unknown address code changes nothing
		host.send_word(24'h0AAAA3, 24);
		check_all(1'b0, 9'h001, 4'h0, 9'h0A5, 24'h01FFDF);
		host.send_word(24'h000004, 24);
		check_all(1'b1, 9'h001, 4'h0, 9'h0A5, 24'h01FFDF);
		host.send_word({10'h000, 9'h007, 5'h0F}, 24);
		check_all(1'b1, 9'h001, 4'h0, 9'h0A5, 24'h01FFDF);
		host.send_word(24'h00005F, 24);
		check_all(1'b1, 9'h001, 4'h0, 9'h0A5, 24'h01FFDF);
		// Second reset in mid-run restores built-in values
		resetn_in = 1'b0;
		@(negedge clock_in);
		check_all(1'b1, 9'h001, 4'h0, 9'h002, 24'h000000);
		resetn_in = 1'b1;
		// After the second release defaults gate again until cleared
		host.send_word({7'h00, 4'h3, 9'h055, 4'h7}, 24);
		check_all(1'b1, 9'h001, 4'h0, 9'h002, 24'h000000);
		host.send_word(24'h000000, 24);
		host.send_word({7'h00, 4'h3, 9'h055, 4'h7}, 24);
		check_all(1'b0, 9'h055, 4'h3, 9'h002, 24'h000000);
		tally_and_finish();
	end
endmodule
`default_nettype wire
